// File: htc_ctrl.sv
// Thermostat and tank-mode supervisory controller, single clock
// Notes on behaviour
// [R1] Heating: outlet over set+2C 3min stops compressor
// [R2] Restart after 3min wait, outlet below latch
// [R3] Internal set recomputed continuously from remote set
// [R4] Tank-only mode holds valve at tank side
// [R5] Tank water set is min(tank set, 50C)
// [R6] Tank mode outlet set forced to 53C
// [R7] Hp off, tank above set+1C 10s: pump off
// [R8] Tank below set-1C: pump 3min, then hp
// [R9] Outlet above 57C for 3min stops hp
// [R10] Latch inlet-3C at off; restart below it
// [R11] Inlet above 55C 60s stops; restart below 55C
// [R12] Booster waits for startup heater delay
// [R13] Booster needs tank below heater-on threshold
// [R14] Booster needs 20 minutes minimum off time
// [R15] Tank above tank set 15s stops booster
// [R16] Backup heater inhibited in tank-only mode
// [R17] Valve output high selects tank side
// [R18] Persistence timers restart when condition drops
// [R19] Booster combines heater-on and min off time
// [R20] All temperatures signed, one common resolution
`timescale 1ns/1ps

module htc_ctrl import htc_pkg::*; #(
	parameter int          TICK_CYCLES        = TICK_CYCLES_DEF,
	parameter htc_sec_type HEATER_DELAY_S     = HEATER_DELAY_DEF,
	parameter bit          BOOST_NEED_MIN_OFF = 1'b1
) (
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic         op_on,
	input  wire logic         tank_mode,
	input  wire htc_temp_type remote_set,
	input  wire htc_temp_type shift_offset,
	input  wire htc_temp_type tank_set,
	input  wire htc_temp_type heater_on_temp,
	input  wire htc_temp_type t_outlet,
	input  wire htc_temp_type t_inlet,
	input  wire htc_temp_type t_tank,
	output htc_temp_type      internal_set,
	output htc_temp_type      water_set,
	output htc_temp_type      outlet_set,
	output logic              comp_en,
	output logic              pump_on,
	output logic              valve_tank,
	output logic              booster_on,
	output logic              backup_inhibit
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Signed a > b + ofs, widened so the sum cannot wrap
	function automatic logic gt(htc_temp_type a, htc_temp_type b,
		htc_temp_type ofs);
		logic signed [TEMP_W:0] lhs;
		logic signed [TEMP_W:0] rhs;
		lhs = {a[TEMP_W-1], a};
		rhs = {b[TEMP_W-1], b} + {ofs[TEMP_W-1], ofs};
		return lhs > rhs; // [R20]
	endfunction

	// Continuous persistence count in seconds, saturating at lim
	function automatic htc_sec_type persist(htc_sec_type cnt, logic cond,
		logic tk, htc_sec_type lim);
		htc_sec_type r;
		r = cnt;
		if (!cond) begin
			r = SEC_ZERO; // [R18]
		end else if (tk && cnt < lim) begin
			r = cnt + SEC_ONE;
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [TICK_W-1:0] tick_cnt;
	logic [TICK_W-1:0] next_tick_cnt;
	htc_state_type     state;
	htc_state_type     next_state;
	logic              last_mode;
	logic              next_last_mode;
	logic              off_inlet;
	logic              next_off_inlet;
	htc_temp_type      restart_thr;
	htc_temp_type      next_restart_thr;
	htc_sec_type       st_cnt;
	htc_sec_type       next_st_cnt;
	htc_sec_type       c_hot;
	htc_sec_type       next_c_hot;
	htc_sec_type       c_inlet;
	htc_sec_type       next_c_inlet;
	htc_sec_type       c_tank;
	htc_sec_type       next_c_tank;
	htc_sec_type       c_boost;
	htc_sec_type       next_c_boost;
	htc_sec_type       boost_off;
	htc_sec_type       next_boost_off;
	htc_sec_type       init_cnt;
	htc_sec_type       next_init_cnt;
	htc_temp_type      next_internal_set;
	htc_temp_type      next_water_set;
	htc_temp_type      next_outlet_set;
	logic              next_comp_en;
	logic              next_pump_on;
	logic              next_valve_tank;
	logic              next_booster_on;
	logic              next_backup_inhibit;

	logic              tick;
	logic              tank_act;
	logic              restart;
	logic              out_hot;
	logic              inlet_hot;
	logic              tank_sat;
	logic              tank_low;
	logic              hot_done;
	logic              inlet_done;
	logic              boost_req;
	htc_sec_type       hot_lim;

	// ------------------------------------------------------------
	// Comparisons and derived thresholds
	// ------------------------------------------------------------
	assign tick     = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
	assign tank_act = op_on && tank_mode;
	assign hot_lim  = tank_mode ? HP_HOT_S : COMP_OFF_S;
	assign out_hot  = tank_mode ? gt(t_outlet, HP_OFF_TEMP, ZERO_OFS) // [R9]
		: gt(t_outlet, internal_set, COMP_OFF_HYST); // [R1]
	assign inlet_hot = gt(t_inlet, INLET_MAX, ZERO_OFS); // [R11]
	assign tank_sat  = gt(t_tank, water_set, TANK_HYST); // [R7]
	assign tank_low  = gt(water_set - TANK_HYST, t_tank, ZERO_OFS); // [R8]
	assign hot_done   = (c_hot == hot_lim); // [R18]
	assign inlet_done = tank_mode && (c_inlet == INLET_HOT_S); // [R11]
	// Restart condition depends on which thermostat tripped
	assign restart = (tank_mode && off_inlet)
		? gt(INLET_MAX, t_inlet, ZERO_OFS) // [R11]
		: gt(restart_thr, t_outlet, ZERO_OFS); // [R2] [R10]
	// Booster enable combination
	assign boost_req = gt(heater_on_temp, t_tank, ZERO_OFS) // [R13]
		&& (!BOOST_NEED_MIN_OFF || boost_off == BOOST_MIN_OFF_S) // [R14] [R19]
		&& (init_cnt == HEATER_DELAY_S); // [R12]

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------

	// Timebase, supervisory FSM, timers and actuator commands
	always_comb begin
		next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
		next_state = state;
		next_last_mode = tank_mode;
		next_off_inlet = off_inlet;
		next_restart_thr = restart_thr;
		next_st_cnt = persist(st_cnt, 1'b1, tick, BOOST_MIN_OFF_S);
		next_c_hot = persist(c_hot, out_hot && state == ST_RUN, tick,
			hot_lim);
		next_c_inlet = persist(c_inlet, inlet_hot && state == ST_RUN, tick,
			INLET_HOT_S);
		next_c_tank = persist(c_tank, tank_sat && state == ST_HOLD, tick,
			TANK_SAT_S);
		next_c_boost = persist(c_boost, booster_on && tank_act
			&& gt(t_tank, tank_set, ZERO_OFS), tick, BOOST_SAT_S); // [R15]
		next_init_cnt = persist(init_cnt, 1'b1, tick, HEATER_DELAY_S);
		next_internal_set = remote_set + shift_offset; // [R3]
		next_water_set = gt(tank_set, TANK_WATER_MAX, ZERO_OFS)
			? TANK_WATER_MAX : tank_set; // [R5]
		next_outlet_set = tank_mode ? TANK_OUTLET_MAX : internal_set; // [R6]
		if (!op_on || tank_mode != last_mode) begin
			next_state = ST_OFF;
			next_st_cnt = SEC_ZERO;
		end else begin
			case (state)
				ST_OFF: begin
					if (!tank_mode) begin
						next_state = ST_RUN;
					end else if (tank_low) begin
						next_state = ST_PREPUMP; // [R8]
						next_st_cnt = SEC_ZERO;
					end
				end
				ST_PREPUMP: begin
					if (st_cnt >= PREPUMP_S) begin
						next_state = ST_RUN; // [R8]
					end
				end
				ST_RUN: begin
					if (hot_done || inlet_done) begin
						next_state = ST_HOLD; // [R1] [R9] [R11]
						next_st_cnt = SEC_ZERO;
						next_off_inlet = inlet_done && !hot_done;
						next_restart_thr = t_inlet - RESTART_HYST; // [R10]
					end
				end
				ST_HOLD: begin
					if (tank_mode && c_tank == TANK_SAT_S) begin
						next_state = ST_OFF; // [R7]
					end else if (restart && (tank_mode
						|| st_cnt >= RESTART_WAIT_S)) begin
						next_state = ST_RUN; // [R2] [R10]
					end
				end
				default: begin
					next_state = ST_OFF;
				end
			endcase
		end
		next_comp_en = (next_state == ST_RUN);
		next_pump_on = (next_state != ST_OFF);
		next_valve_tank = tank_act; // [R4] [R17]
		next_backup_inhibit = tank_act; // [R16]
		// Booster: off on satisfaction or leaving tank mode
		next_booster_on = booster_on;
		next_boost_off = persist(boost_off, !booster_on, tick,
			BOOST_MIN_OFF_S); // [R14]
		if (booster_on && (!tank_act || c_boost == BOOST_SAT_S)) begin
			next_booster_on = 1'b0; // [R15]
			next_boost_off = SEC_ZERO;
		end else if (!booster_on && tank_act && boost_req) begin
			next_booster_on = 1'b1; // [R12] [R13] [R14]
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------

	// Synchronous reset; min off timer starts already satisfied
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tick_cnt       <= '0;
			state          <= ST_OFF;
			last_mode      <= 1'b0;
			off_inlet      <= 1'b0;
			restart_thr    <= ZERO_OFS;
			st_cnt         <= SEC_ZERO;
			c_hot          <= SEC_ZERO;
			c_inlet        <= SEC_ZERO;
			c_tank         <= SEC_ZERO;
			c_boost        <= SEC_ZERO;
			boost_off      <= BOOST_MIN_OFF_S;
			init_cnt       <= SEC_ZERO;
			internal_set   <= ZERO_OFS;
			water_set      <= ZERO_OFS;
			outlet_set     <= ZERO_OFS;
			comp_en        <= 1'b0;
			pump_on        <= 1'b0;
			valve_tank     <= 1'b0;
			booster_on     <= 1'b0;
			backup_inhibit <= 1'b0;
		end else begin
			tick_cnt       <= next_tick_cnt;
			state          <= next_state;
			last_mode      <= next_last_mode;
			off_inlet      <= next_off_inlet;
			restart_thr    <= next_restart_thr;
			st_cnt         <= next_st_cnt;
			c_hot          <= next_c_hot;
			c_inlet        <= next_c_inlet;
			c_tank         <= next_c_tank;
			c_boost        <= next_c_boost;
			boost_off      <= next_boost_off;
			init_cnt       <= next_init_cnt;
			internal_set   <= next_internal_set;
			water_set      <= next_water_set;
			outlet_set     <= next_outlet_set;
			comp_en        <= next_comp_en;
			pump_on        <= next_pump_on;
			valve_tank     <= next_valve_tank;
			booster_on     <= next_booster_on;
			backup_inhibit <= next_backup_inhibit;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// Operating in tank-only mode, steady for two cycles
	sequence s_tank_steady;
		tank_act [*2];
	endsequence

	// Compressor stopped while mode and power were unchanged
	sequence s_hp_stop;
		$fell(comp_en) && $past(op_on && tank_mode == last_mode)
			&& $past(state) == ST_RUN;
	endsequence

	AST_VALVE_TANK: assert property (s_tank_steady |-> valve_tank) // [R4]
		else $error("valve not at tank side in tank mode");
	AST_BACKUP_OFF: assert property (s_tank_steady |-> backup_inhibit) // [R16]
		else $error("backup heater not inhibited in tank mode");
	AST_WATER_MAX: assert property ( // [R5]
		!gt(water_set, TANK_WATER_MAX, ZERO_OFS))
		else $error("tank water set above limit");
	AST_OUTLET_MAX: assert property ( // [R6]
		s_tank_steady |-> outlet_set == TANK_OUTLET_MAX)
		else $error("tank outlet set not at maximum");
	AST_HP_STOP: assert property ( // [R1] [R9] [R11]
		s_hp_stop |-> $past(hot_done || inlet_done))
		else $error("heat pump stopped before persistence expiry");
	AST_LATCH: assert property ( // [R10]
		s_hp_stop |-> restart_thr == $past(t_inlet) - RESTART_HYST)
		else $error("restart threshold not latched at thermo off");
	AST_WAIT: assert property ( // [R2]
		$rose(comp_en) && !tank_mode && $past(state) == ST_HOLD
		|-> $past(st_cnt) >= RESTART_WAIT_S)
		else $error("compressor restarted before wait");
	AST_PREPUMP: assert property ( // [R8]
		$rose(comp_en) && $past(state) == ST_PREPUMP
		|-> $past(st_cnt) >= PREPUMP_S && pump_on)
		else $error("heat pump enabled before pre-pump time");
	AST_PUMP_OFF: assert property ( // [R7]
		$fell(pump_on) && $past(tank_act) && tank_act
		|-> $past(c_tank) == TANK_SAT_S)
		else $error("pump stopped before tank persistence");
	AST_BOOST_ON: assert property ( // [R12] [R14]
		$rose(booster_on) |-> $past(init_cnt) == HEATER_DELAY_S
		&& (!BOOST_NEED_MIN_OFF || $past(boost_off) == BOOST_MIN_OFF_S))
		else $error("booster on before delay or min off time");
	AST_BOOST_OFF: assert property ( // [R15]
		$fell(booster_on) && $past(tank_act)
		|-> $past(c_boost) == BOOST_SAT_S)
		else $error("booster stopped before persistence");
	AST_RESTART0: assert property (!out_hot |=> c_hot == SEC_ZERO) // [R18]
		else $error("persistence timer not cleared");

endmodule // htc_ctrl

// File: htc_pkg.sv
// Constants and types for the heat pump tank thermostat controller
package htc_pkg;

	// ------------------------------------------------------------
	// Temperature representation: signed, 0.1 degC per LSB
	// ------------------------------------------------------------
	localparam int TEMP_W = 12;
	typedef logic signed [TEMP_W-1:0] htc_temp_type;

	localparam htc_temp_type ZERO_OFS        = 12'sh000;
	localparam htc_temp_type COMP_OFF_HYST   = 12'sh014; // 2.0 degC
	localparam htc_temp_type RESTART_HYST    = 12'sh01e; // 3.0 degC
	localparam htc_temp_type TANK_WATER_MAX  = 12'sh1f4; // 50.0 degC
	localparam htc_temp_type TANK_OUTLET_MAX = 12'sh212; // 53.0 degC
	localparam htc_temp_type HP_OFF_HYST     = 12'sh028; // 4.0 degC
	localparam htc_temp_type INLET_MAX       = 12'sh226; // 55.0 degC
	localparam htc_temp_type TANK_HYST       = 12'sh00a; // 1.0 degC
	localparam htc_temp_type HP_OFF_TEMP     = TANK_OUTLET_MAX + HP_OFF_HYST;

	// ------------------------------------------------------------
	// Timebase and second-scale durations
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 50;
	localparam int SEC_NS          = 1000000000;
	localparam int TICK_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
	localparam int TICK_W          = 25;
	localparam int SEC_W           = 11;
	typedef logic [SEC_W-1:0] htc_sec_type;

	localparam htc_sec_type SEC_ZERO        = 11'h000;
	localparam htc_sec_type SEC_ONE         = 11'h001;
	localparam htc_sec_type COMP_OFF_S      = 11'h0b4; // 3 minutes
	localparam htc_sec_type RESTART_WAIT_S  = 11'h0b4; // 3 minutes
	localparam htc_sec_type PREPUMP_S       = 11'h0b4; // 3 minutes
	localparam htc_sec_type HP_HOT_S        = 11'h0b4; // 3 minutes
	localparam htc_sec_type INLET_HOT_S     = 11'h03c; // 60 seconds
	localparam htc_sec_type TANK_SAT_S      = 11'h00a; // 10 seconds
	localparam htc_sec_type BOOST_SAT_S     = 11'h00f; // 15 seconds
	localparam htc_sec_type BOOST_MIN_OFF_S = 11'h4b0; // 20 minutes
	localparam htc_sec_type HEATER_DELAY_DEF = 11'h03c;

	// ------------------------------------------------------------
	// Supervisory states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_OFF,
		ST_PREPUMP,
		ST_RUN,
		ST_HOLD
	} htc_state_type;

endpackage

// File: htc_sensor.sv
// Sensor front-end model feeding water and tank temperatures
`timescale 1ns/1ps

module htc_sensor import htc_pkg::*; (
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire htc_temp_type want_outlet,
	input  wire htc_temp_type want_inlet,
	input  wire htc_temp_type want_tank,
	output htc_temp_type      t_outlet,
	output htc_temp_type      t_inlet,
	output htc_temp_type      t_tank
);
	// One conversion per cycle, same signed 0.1 degC scale
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			t_outlet <= 12'sh000;
			t_inlet  <= 12'sh000;
			t_tank   <= 12'sh000;
		end else begin
			t_outlet <= want_outlet;
			t_inlet  <= want_inlet;
			t_tank   <= want_tank;
		end
	end
endmodule // htc_sensor

// File: tb.sv
// Self-checking testbench for the tank thermostat controller
`timescale 1ns/1ps

module tb import htc_pkg::*; ();
	logic         sys_clk        = 1'b0;
	logic         srst           = 1'b1;
	logic         op_on          = 1'b0;
	logic         tank_mode      = 1'b0;
	htc_temp_type remote_set     = 12'sh190;
	htc_temp_type shift_offset   = 12'sh014;
	htc_temp_type tank_set       = 12'sh226;
	htc_temp_type heater_on_temp = 12'sh1f4;
	htc_temp_type want_outlet    = 12'sh190;
	htc_temp_type want_inlet     = 12'sh190;
	htc_temp_type want_tank      = 12'sh1e0;
	htc_temp_type t_outlet, t_inlet, t_tank;
	htc_temp_type internal_set, water_set, outlet_set;
	logic         comp_en, pump_on, valve_tank, booster_on, backup_inhibit;
	int           n_mismatch     = 0;
	int           checked        = 0;
	int           cyc            = 0;
	int           toff;

	// Clock, cycle count and the two blocks
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	htc_sensor plant (.sys_clk(sys_clk), .srst(srst), .want_outlet(want_outlet),
		.want_inlet(want_inlet), .want_tank(want_tank), .t_outlet(t_outlet),
		.t_inlet(t_inlet), .t_tank(t_tank));

	htc_ctrl #(.TICK_CYCLES(10), .HEATER_DELAY_S(11'h0c8),
		.BOOST_NEED_MIN_OFF(1'b1)) uut (.sys_clk(sys_clk), .srst(srst),
		.op_on(op_on), .tank_mode(tank_mode), .remote_set(remote_set),
		.shift_offset(shift_offset), .tank_set(tank_set),
		.heater_on_temp(heater_on_temp), .t_outlet(t_outlet),
		.t_inlet(t_inlet), .t_tank(t_tank), .internal_set(internal_set),
		.water_set(water_set), .outlet_set(outlet_set), .comp_en(comp_en),
		.pump_on(pump_on), .valve_tank(valve_tank), .booster_on(booster_on),
		.backup_inhibit(backup_inhibit));

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	function automatic logic sel(input int k);
		case (k)
			0:       return comp_en;
			1:       return pump_on;
			default: return booster_on;
		endcase
	endfunction

	task automatic fail(input string msg);
		n_mismatch++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask

	task automatic temps(input htc_temp_type o, i, t);
		@(posedge sys_clk);
		want_outlet <= o;
		want_inlet  <= i;
		want_tank   <= t;
	endtask

	task automatic chk(input logic [11:0] got, exp, input string msg);
		@(negedge sys_clk);
		checked++;
		if (got !== exp) fail(msg);
	endtask

	// Output k keeps off v for lo cycles, then reaches v within hi
	// A hi of 0 checks the hold only
	task automatic expect_out(input int k, input logic v, input int lo, hi);
		int n;
		checked++;
		for (n = 0; n < lo; n++) begin
			@(negedge sys_clk);
			if (sel(k) === v) begin
				fail($sformatf("output %0d changed early", k));
				return;
			end
		end
		if (hi == 0) return;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (sel(k) !== v && n < hi);
		if (sel(k) !== v) fail($sformatf("output %0d changed late", k));
	endtask

	task automatic print_verdict();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tank mode, then heating
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge sys_clk);
		srst      <= 1'b0;
		op_on     <= 1'b1;
		tank_mode <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(water_set, TANK_WATER_MAX, "water set");
		chk(outlet_set, TANK_OUTLET_MAX, "outlet set");
		chk(valve_tank, 12'h001, "valve side");
		chk(backup_inhibit, 12'h001, "backup heater");
		expect_out(1, 1'b1, 0, 5);
		expect_out(0, 1'b1, 1700, 200);
		expect_out(2, 1'b1, 100, 250);
		temps(12'sh23b, 12'sh190, 12'sh1e0);
		expect_out(0, 1'b0, 1700, 200);
		temps(12'sh172, 12'sh190, 12'sh1e0);
		expect_out(0, 1'b1, 300, 0);
		temps(12'sh168, 12'sh190, 12'sh1e0);
		expect_out(0, 1'b1, 0, 5);
		temps(12'sh190, 12'sh227, 12'sh1e0);
		expect_out(0, 1'b0, 550, 100);
		temps(12'sh190, 12'sh225, 12'sh1e0);
		expect_out(0, 1'b1, 0, 5);
		temps(12'sh190, 12'sh225, 12'sh230);
		expect_out(2, 1'b0, 130, 40);
		toff = cyc;
		temps(12'sh23b, 12'sh225, 12'sh230);
		expect_out(0, 1'b0, 1700, 200);
		expect_out(1, 1'b0, 85, 40);
		temps(12'sh190, 12'sh190, 12'sh1e0);
		expect_out(1, 1'b1, 0, 5);
		expect_out(2, 1'b1, 11900 - (cyc - toff), 300);
		@(posedge sys_clk);
		tank_mode <= 1'b0;
		temps(12'sh1ae, 12'sh12c, 12'sh1e0);
		expect_out(0, 1'b1, 0, 5);
		chk(valve_tank, 12'h000, "valve rest");
		chk(backup_inhibit, 12'h000, "backup free");
		chk(internal_set, 12'h1a4, "internal set");
		chk(outlet_set, 12'h1a4, "heating outlet set");
		@(posedge sys_clk);
		remote_set <= 12'sh1c2;
		repeat (2) @(posedge sys_clk);
		chk(internal_set, 12'h1d6, "set update");
		temps(12'sh1eb, 12'sh12c, 12'sh1e0);
		repeat (1000) @(posedge sys_clk);
		temps(12'sh1ea, 12'sh12c, 12'sh1e0);
		repeat (2) @(posedge sys_clk);
		temps(12'sh1eb, 12'sh12c, 12'sh1e0);
		expect_out(0, 1'b0, 1700, 200);
		temps(12'sh104, 12'sh12c, 12'sh1e0);
		expect_out(0, 1'b1, 1700, 200);
		print_verdict();
	end

	// Cuts a hung run short
	initial begin
		#2000000;
		fail("timeout");
		print_verdict();
	end
endmodule // tb
